// ===== core/irr_pkg.sv
package irr_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IRR_CCR_OFS    = 8'h00;
  localparam logic [7:0] IRR_EXT_OFS    = 8'h04;
  localparam logic [7:0] IRR_CTRL_OFS   = 8'h08;
  localparam logic [7:0] IRR_STAT_OFS   = 8'h0C;
  localparam logic [7:0] IRR_VEC0_OFS   = 8'h10;
  localparam logic [7:0] IRR_VEC1_OFS   = 8'h14;
  localparam logic [7:0] IRR_VEC2_OFS   = 8'h18;
  localparam logic [7:0] IRR_VEC3_OFS   = 8'h1C;

  // ****************************************
  // condition code fields
  // ****************************************
  localparam int         IRR_MASK_LSB   = 5;
  localparam int         IRR_MASK_MSB   = 7;
  localparam int         IRR_STOPDIS_BIT = 8;
  localparam int         IRR_SAT_BIT    = 4;
  localparam logic [2:0] IRR_MASK_RST   = 3'h7;
  localparam logic [2:0] IRR_TOP_LEVEL  = 3'h7;

  // ****************************************
  // control / status fields
  // ****************************************
  localparam int         IRR_CTRL_BOUND_BIT = 0;
  localparam int         IRR_CTRL_DONE_BIT  = 1;

  // ****************************************
  // vectors
  // ****************************************
  localparam int         IRR_NUM_LEVELS  = 7;
  localparam int         IRR_NUM_AUTOVEC = 7;
  localparam int         IRR_NUM_USERVEC = 200;
  localparam logic [9:0] IRR_VEC_TABLE_BYTES = 10'h200;
  localparam logic [7:0] IRR_AUTOVEC_BASE = 8'h18;
  localparam logic [1:0] IRR_NUM_RST_VEC  = 2'h3;

  typedef enum logic [3:0] {
    IRR_RST_HOLD  = 4'b0001,
    IRR_RST_BREAKPOINT_INPUT  = 4'b0010,
    IRR_RST_FETCH = 4'b0100,
    IRR_RST_RUN   = 4'b1000
  } irr_rst_t;

endpackage : irr_pkg

// ===== core/irr_top.sv
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - seven levels 1..7, seven autovectors, 200 user vectors.
// - request line n maps to level n; 1 lowest, 7 highest.
// - mask is three bits, condition code bits 7 to 5.
// - level at or below mask ignored, except 7; mask zero passes all.
// - level 7 recognised whatever the mask holds.
// - taking an interrupt loads the mask with its level.
// - request lines are active low and level sensitive, levels 1..6.
// - level 7 needs a fresh falling edge; held low repeats nothing.
// - mask write while level 7 held low raises a new level 7.
// - lines sampled each cycle; valid after two consecutive asserted samples.
// - valid requests wait pending until a boundary or higher exception ends.
// - pending level not latched; a higher arrival wins.
// - several unmasked requests: highest level recognised.
// - pin requests merge with internal bus requests.
// - vectors in first 512 bytes of bank 0, offset from vector number.
// - reset acts at end of current bus cycle, aborting work.
// - master reset: mask 7, stop disable set, saturation clear, extension clear.
// - other condition code bits keep their values through reset.
// - after reset: sample breakpoint, fetch extension, pc, sp, index z, run.
// - acknowledge cycle drives the level onto address bits 3 to 1.
module irr_top
  import irr_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:1]  REQ_PIN_N_I,
  input  wire logic [7:1]  REQ_BUS_N_I,
  input  wire logic        BUS_CYCLE_END_I,
  input  wire logic        BREAKPOINT_INPUT_N_I,
  output logic             IACK_O,
  output logic      [3:1]  ACK_ADDR_O,
  output logic      [8:0]  VEC_ADDR_O,
  output logic             MASTER_RESET_O,
  output logic             RESET_FETCH_O,
  output logic      [1:0]  RESET_FETCH_IDX_O,
  output logic             RUN_O,
  output logic             BREAKPOINT_INPUT_SEEN_O
);

  // ****************************************
  // request synchronisers and qualification
  // ****************************************
  logic [7:1] pin_s1_q, pin_s2_q, bus_s1_q, bus_s2_q;
  logic [7:1] samp_q, valid_q;
  logic [7:1] raw_req;
  logic       top_prev_q;
  logic       breakpoint_input_s1_q, breakpoint_input_s2_q;

  always_ff @(posedge CLK_I) begin
    pin_s1_q <= ~REQ_PIN_N_I;
    pin_s2_q <= pin_s1_q;
    bus_s1_q <= ~REQ_BUS_N_I;
    bus_s2_q <= bus_s1_q;
    // breakpoint is a pin too: two flops before the sequencer looks
    breakpoint_input_s1_q <= ~BREAKPOINT_INPUT_N_I;
    breakpoint_input_s2_q <= breakpoint_input_s1_q;
  end

  // pins look like the integration module's own bus request
  assign raw_req = pin_s2_q | bus_s2_q;

  // hysteresis: two agreeing samples before a change is believed
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      samp_q  <= 7'h00;
      valid_q <= 7'h00;
    end else begin
      samp_q <= raw_req;
      for (int i = 1; i <= 7; i++) begin
        if (samp_q[i] == raw_req[i]) begin
          valid_q[i] <= raw_req[i];
        end
      end
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  logic        ph_wr_q, ph_rd_q;
  logic [7:0]  ph_addr_q;
  logic [15:0] ccr_q;
  logic [11:0] ext_q;
  logic [31:0] vec_q [0:3];
  logic        bound_q, done_q;
  logic        mask_wr;
  logic [2:0]  mask;
  logic        req_now;

  assign mask = ccr_q[IRR_MASK_MSB:IRR_MASK_LSB];

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_wr_q   <= HSEL & HREADY & HTRANS[1] & HWRITE;
      ph_rd_q   <= HSEL & HREADY & HTRANS[1] & ~HWRITE;
      ph_addr_q <= HADDR[7:0];
    end
  end

  assign mask_wr = ph_wr_q && (ph_addr_q == IRR_CCR_OFS);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      if (HSEL & HREADY & HTRANS[1] & ~HWRITE) begin
        unique case (HADDR[7:0])
          IRR_CCR_OFS:  HRDATA <= {16'h0000, ccr_q};
          IRR_EXT_OFS:  HRDATA <= {20'h00000, ext_q};
          IRR_CTRL_OFS: HRDATA <= 32'h0000_0000;
          IRR_STAT_OFS: HRDATA <= {21'h000000, req_now, BREAKPOINT_INPUT_SEEN_O, RUN_O,
                                   valid_q, MASTER_RESET_O};
          IRR_VEC0_OFS: HRDATA <= vec_q[0];
          IRR_VEC1_OFS: HRDATA <= vec_q[1];
          IRR_VEC2_OFS: HRDATA <= vec_q[2];
          IRR_VEC3_OFS: HRDATA <= vec_q[3];
          default:      HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // instruction boundary and exception-done strobes, one cycle each
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bound_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      bound_q <= mask_wr ? 1'b0 : 1'b0;
      done_q  <= 1'b0;
      if (ph_wr_q && ph_addr_q == IRR_CTRL_OFS) begin
        bound_q <= HWDATA[IRR_CTRL_BOUND_BIT];
        done_q  <= HWDATA[IRR_CTRL_DONE_BIT];
      end
    end
  end

  // reset vector words are software loaded; kept across reset
  always_ff @(posedge CLK_I) begin
    if (ph_wr_q) begin
      unique case (ph_addr_q)
        IRR_VEC0_OFS: vec_q[0] <= HWDATA;
        IRR_VEC1_OFS: vec_q[1] <= HWDATA;
        IRR_VEC2_OFS: vec_q[2] <= HWDATA;
        IRR_VEC3_OFS: vec_q[3] <= HWDATA;
        default: ;
      endcase
    end
  end

  // ****************************************
  // level 7 edge detection
  // ****************************************
  logic top_event_q;
  logic take;
  logic [2:0] win_lvl;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      top_prev_q  <= 1'b0;
      top_event_q <= 1'b0;
    end else begin
      top_prev_q <= valid_q[7];
      // new edge or mask write while held low both arm it; set wins clear
      if ((valid_q[7] && !top_prev_q) || (valid_q[7] && mask_wr)) begin
        top_event_q <= 1'b1;
      end else if (take && win_lvl == IRR_TOP_LEVEL) begin
        top_event_q <= 1'b0;
      end else if (!valid_q[7]) begin
        top_event_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // recognition: highest unmasked level
  // ****************************************
  logic [7:1] eligible;
  always_comb begin
    eligible = 7'h00;
    for (int i = 1; i <= 6; i++) begin
      eligible[i] = valid_q[i] && (3'(i) > mask);
    end
    eligible[7] = top_event_q;
    win_lvl = 3'h0;
    for (int i = 1; i <= 7; i++) begin
      if (eligible[i]) begin
        win_lvl = 3'(i);
      end
    end
  end

  assign req_now = (win_lvl != 3'h0);
  // no level latched while pending; decided only at a boundary or exception-done strobe
  assign take = req_now && (bound_q || done_q) && RUN_O;

  // ****************************************
  // reset sequencing
  // ****************************************
  irr_rst_t   rst_st_q;
  logic       rst_pend_q;
  logic [1:0] fetch_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rst_pend_q <= 1'b1;
    end else if (BUS_CYCLE_END_I) begin
      rst_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rst_st_q          <= IRR_RST_HOLD;
      fetch_q           <= 2'h0;
      MASTER_RESET_O    <= 1'b1;
      RESET_FETCH_O     <= 1'b0;
      RESET_FETCH_IDX_O <= 2'h0;
      RUN_O             <= 1'b0;
      BREAKPOINT_INPUT_SEEN_O       <= 1'b0;
    end else begin
      RESET_FETCH_O <= 1'b0;
      unique case (rst_st_q)
        IRR_RST_HOLD: begin
          // drop on the edge that sees the bus cycle end, not one later
          if (rst_pend_q && BUS_CYCLE_END_I) begin
            MASTER_RESET_O <= 1'b0;
            rst_st_q       <= IRR_RST_BREAKPOINT_INPUT;
          end
        end
        IRR_RST_BREAKPOINT_INPUT: begin
          BREAKPOINT_INPUT_SEEN_O <= breakpoint_input_s2_q;
          rst_st_q    <= IRR_RST_FETCH;
        end
        IRR_RST_FETCH: begin
          RESET_FETCH_O     <= 1'b1;
          RESET_FETCH_IDX_O <= fetch_q;
          fetch_q           <= fetch_q + 2'h1;
          if (fetch_q == IRR_NUM_RST_VEC) begin
            rst_st_q <= IRR_RST_RUN;
            RUN_O    <= 1'b1;
          end
        end
        IRR_RST_RUN: ;
      endcase
    end
  end

  // ****************************************
  // condition code and extension state
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (MASTER_RESET_O) begin
      // other bits keep their value across reset
      ccr_q[IRR_MASK_MSB:IRR_MASK_LSB] <= IRR_MASK_RST;
      ccr_q[IRR_STOPDIS_BIT]           <= 1'b1;
      ccr_q[IRR_SAT_BIT]               <= 1'b0;
    end else if (take) begin
      ccr_q[IRR_MASK_MSB:IRR_MASK_LSB] <= win_lvl;
    end else if (mask_wr) begin
      ccr_q <= HWDATA[15:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (MASTER_RESET_O) begin
      ext_q <= 12'h000;
    end else if (ph_wr_q && ph_addr_q == IRR_EXT_OFS) begin
      ext_q <= HWDATA[11:0];
    end else if (RESET_FETCH_O && RESET_FETCH_IDX_O == 2'h0) begin
      ext_q <= vec_q[0][11:0];
    end
  end

  // ****************************************
  // acknowledge cycle
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IACK_O     <= 1'b0;
      ACK_ADDR_O <= 3'h0;
      VEC_ADDR_O <= 9'h000;
    end else begin
      IACK_O <= take;
      if (take) begin
        ACK_ADDR_O <= win_lvl;
        // autovector byte offset inside the 512-byte bank 0 table
        VEC_ADDR_O <= 9'({IRR_AUTOVEC_BASE + 8'(win_lvl), 1'b0});
      end
    end
  end

endmodule : irr_top

// ===== testbench/irr_asserts.sv
`timescale 1ns/1ps
// ***
// port checker
// ***
module irr_asserts
  import irr_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       BUS_CYCLE_END_I,
  input wire logic       BREAKPOINT_INPUT_N_I,
  input wire logic       IACK_O,
  input wire logic [3:1] ACK_ADDR_O,
  input wire logic [8:0] VEC_ADDR_O,
  input wire logic       MASTER_RESET_O,
  input wire logic       RESET_FETCH_O,
  input wire logic [1:0] RESET_FETCH_IDX_O,
  input wire logic       RUN_O,
  input wire logic       BREAKPOINT_INPUT_SEEN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_fetch(logic [1:0] k);
    RESET_FETCH_O && RESET_FETCH_IDX_O == k;
  endsequence
  a_ack_vec: assert property (IACK_O |->
    VEC_ADDR_O == ((9'(IRR_AUTOVEC_BASE) + 9'(ACK_ADDR_O)) << 1)) else $error("bad vector");
  a_ack_level: assert property (IACK_O |-> ACK_ADDR_O != 3'h0)
    else $error("ack level zero");
  a_ack_pulse: assert property (IACK_O |=> !IACK_O)
    else $error("ack too long");
  // reset itself is the cause here, so no disable
  a_mr_reset: assert property (disable iff (1'b0) RST_I |=> MASTER_RESET_O)
    else $error("no master reset");
  a_mr_hold: assert property (MASTER_RESET_O && !BUS_CYCLE_END_I |=> MASTER_RESET_O)
    else $error("reset left mid cycle");
  a_mr_release: assert property ($fell(MASTER_RESET_O) |-> $past(BUS_CYCLE_END_I))
    else $error("reset left without cycle end");
  a_quiet_rst: assert property (MASTER_RESET_O |-> !IACK_O && !RUN_O)
    else $error("activity in reset");
  a_first_fetch: assert property ($fell(MASTER_RESET_O) |-> ##[1:4] s_fetch(2'h0))
    else $error("first fetch late");
  a_fetch_order: assert property (s_fetch(2'h0) |->
    ##[1:8] s_fetch(2'h1) ##[1:8] s_fetch(2'h2) ##[1:8] s_fetch(2'h3)) else $error("fetch order");
  a_run_start: assert property ($rose(RUN_O) |-> s_fetch(2'h3))
    else $error("run early");
  a_breakpoint_input_seen: assert property (s_fetch(2'h0) |-> BREAKPOINT_INPUT_SEEN_O == !BREAKPOINT_INPUT_N_I)
    else $error("breakpoint sample");
endmodule : irr_asserts

bind irr_top irr_asserts u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .BUS_CYCLE_END_I(BUS_CYCLE_END_I),
  .BREAKPOINT_INPUT_N_I(BREAKPOINT_INPUT_N_I), .IACK_O(IACK_O), .ACK_ADDR_O(ACK_ADDR_O),
  .VEC_ADDR_O(VEC_ADDR_O), .MASTER_RESET_O(MASTER_RESET_O), .RESET_FETCH_O(RESET_FETCH_O),
  .RESET_FETCH_IDX_O(RESET_FETCH_IDX_O), .RUN_O(RUN_O), .BREAKPOINT_INPUT_SEEN_O(BREAKPOINT_INPUT_SEEN_O));

// ===== testbench/irr_src_model.sv
`timescale 1ns/1ps
// ***
// requesting sources
// ***
module irr_src_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       iack_i,
  input  wire logic [2:0] ack_lvl_i,
  input  wire logic [7:1] raise_i,
  output logic      [7:1] req_n_o
);
  // a source lets go only on its own level's acknowledge or on reset
  always_ff @(posedge clk_i) begin
    for (int l = 1; l <= 7; l++) begin
      if (rst_i) begin
        req_n_o[l] <= 1'b1;
      end else if (raise_i[l]) begin
        req_n_o[l] <= 1'b0;
      end else if (iack_i && ack_lvl_i == 3'(l)) begin
        req_n_o[l] <= 1'b1;
      end
    end
  end
endmodule : irr_src_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
// ***
// bench top
// ***
module testbench
  import irr_pkg::*;
();
  logic        clk, rst, hsel, hwrite, bce, breakpoint_input_n, hrdy, hresp, iack, mrst, fetch, run, breakpoint_input;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, fidx;
  logic [2:0]  hsize, ack_addr;
  logic [8:0]  vec;
  logic [7:1]  pin_n, bus_n, raise_v;
  int          errors, n_compared;

  irr_top dut (.CLK_I(clk), .RST_I(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .REQ_PIN_N_I(pin_n), .REQ_BUS_N_I(bus_n),
    .BUS_CYCLE_END_I(bce), .BREAKPOINT_INPUT_N_I(breakpoint_input_n), .IACK_O(iack), .ACK_ADDR_O(ack_addr),
    .VEC_ADDR_O(vec), .MASTER_RESET_O(mrst), .RESET_FETCH_O(fetch), .RESET_FETCH_IDX_O(fidx),
    .RUN_O(run), .BREAKPOINT_INPUT_SEEN_O(breakpoint_input));
  irr_src_model u_src (.clk_i(clk), .rst_i(rst), .iack_i(iack), .ack_lvl_i(ack_addr),
    .raise_i(raise_v), .req_n_o(bus_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h got %h", what, exp, got);
    end
  endtask : chk

  // single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] m, e);
    ahb(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask : rdchk

  task automatic mask(input logic [2:0] m);
    ahb(1'b1, IRR_CCR_OFS, {24'h0, m, 5'h0});
  endtask : mask

  task automatic fire(input logic [7:1] v);
    raise_v <= v;
    @(posedge clk);
    raise_v <= 7'h0;
    repeat (6) @(posedge clk);
  endtask : fire

  // strobe a boundary or exception end, then watch for the acknowledge
  task automatic take(input logic [31:0] ctl, input logic [2:0] exp);
    logic [2:0] lv;
    lv = 3'h0;
    ahb(1'b1, IRR_CTRL_OFS, ctl);
    repeat (8) begin
      @(posedge clk);
      if (iack === 1'b1) lv = ack_addr;
    end
    chk("ack level", {29'h0, exp}, {29'h0, lv});
    if (exp != 3'h0) rdchk("mask", IRR_CCR_OFS, 32'hE0, {24'h0, exp, 5'h0});
  endtask : take

  task automatic do_reset(input logic bk);
    breakpoint_input_n <= bk;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk("ccr init", IRR_CCR_OFS, 32'h1F0, 32'h1E0);
    rdchk("ext init", IRR_EXT_OFS, 32'hFFF, 32'h0);
    rdchk("held", IRR_STAT_OFS, 32'h1, 32'h1);
    bce <= 1'b1;
    @(posedge clk);
    bce <= 1'b0;
    for (int i = 0; i < 30 && run !== 1'b1; i++) @(posedge clk);
    chk("run", 32'h1, {31'h0, run});
    rdchk("breakpoint_input", IRR_STAT_OFS, 32'h200, {22'h0, ~bk, 9'h0});
  endtask : do_reset

  task automatic t_init();
    do_reset(1'b0);
    rdchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, IRR_CCR_OFS, 32'h1F);
    ahb(1'b1, IRR_EXT_OFS, 32'hABC);
    do_reset(1'b1);
    rdchk("ccr kept", IRR_CCR_OFS, 32'h1FF, 32'h1EF);
    $display("test init done");
  endtask : t_init

  task automatic t_mask();
    mask(3'h3);
    fire(7'h04);
    take(32'h1, 3'h0);
    rdchk("pending", IRR_STAT_OFS, 32'h8, 32'h8);
    mask(3'h2);
    take(32'h1, 3'h3);
    mask(3'h0);
    fire(7'h01);
    take(32'h2, 3'h1);
    $display("test mask done");
  endtask : t_mask

  task automatic t_prio();
    mask(3'h0);
    pin_n <= 7'h7D;
    fire(7'h18);
    take(32'h1, 3'h5);
    mask(3'h0);
    take(32'h1, 3'h4);
    mask(3'h0);
    take(32'h1, 3'h2);
    pin_n <= 7'h7F;
    $display("test prio done");
  endtask : t_prio

  task automatic t_top();
    mask(3'h7);
    pin_n <= 7'h3F;
    repeat (6) @(posedge clk);
    take(32'h1, 3'h7);
    take(32'h1, 3'h0);
    mask(3'h7);
    take(32'h1, 3'h7);
    pin_n <= 7'h7F;
    mask(3'h0);
    pin_n <= 7'h5F;
    @(posedge clk);
    pin_n <= 7'h7F;
    repeat (6) @(posedge clk);
    take(32'h1, 3'h0);
    $display("test top done");
  endtask : t_top

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_n = 7'h7F;
    raise_v = 7'h0;
    bce = 1'b0;
    breakpoint_input_n = 1'b1;
    t_init();
    t_mask();
    t_prio();
    t_top();
    print_verdict();
  end
endmodule : testbench
